// file: amci_cmd.sv
// Command interpreter for pre-erase, cache flush, format and identify
// Summary of operation
// - Pre-erase target taken from task file registers
// - Pre-erase moves no data; may end in fault
// - Flush completes after cache drain, ready and seek
// - Unsupported flush ends with command aborted
// - Format writes fixed pattern to addressed track
// - Format accepts one sector, contents discarded
// - LBA format count from sector count, zero=256
// - Identify returns block like sector read
// - Word 0 holds fixed configuration signature
// - PCMCIA modes report signature only in word 0
// - Words 1,3,6 default geometry
// - Words 7-8 sectors per card, high first
// - Words 10-19 serial number, right justified
// - Word 22 ECC byte count of four
// - Words 23-26 firmware revision, upper first
// - Words 27-46 model string, upper first
// - Word 47 maximum sectors per multiple block
// - Words 54-56 current geometry
// - Words 57-58 capacity, low half first
// - Words 60-61 total LBA sectors
// - Words 63,65,66 zero in PCMCIA mode
// - Word 59 bit 8 valid, low sector count
`include "amci_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module amci_cmd
  import amci_pkg::*;
#(
  parameter logic [15:0] SIGNATURE  = 16'h5A5A,  // Arbitrary value
  parameter logic [15:0] CONFIG_IDE = 16'h0040,
  parameter logic [159:0] SERIAL    = {20{8'h20}},
  parameter logic [63:0]  FIRMWARE  = {8{8'h20}},
  parameter logic [319:0] MODEL     = {40{8'h20}},
  parameter bit FLUSH_SUPPORTED     = 1'b1
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        wr_strobe,
  input  wire logic        rd_strobe,
  input  wire logic [2:0]  addr,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] rd_data,
  output logic      [7:0]  status,
  output logic      [7:0]  error,
  output logic             host_irq,
  input  wire amci_geom_t  def_geom,
  input  wire amci_geom_t  cur_geom,
  input  wire amci_card_t  card,
  output logic             flush_req,
  input  wire logic        flush_done,
  output logic             media_wr,
  output logic      [27:0] media_addr,
  output logic      [15:0] media_data,
  output logic             erase_req,
  input  wire logic        op_done,
  input  wire logic        op_fault
);
  amci_state_t state;
  logic [7:0]  feature_param;
  logic [7:0]  sector_count;
  logic [7:0]  sector_number_lba_low;
  logic [7:0]  cylinder_low_lba_mid;
  logic [7:0]  cylinder_high_lba_high;
  logic [7:0]  drive_head_select;
  logic [7:0]  command_code;
  logic [8:0]  word_idx;
  logic [8:0]  fmt_left;
  logic        busy;
  logic        drq;
  logic        fault;
  logic        err;
  logic        seek_complete_flag;
  logic [15:0] id_word;
  logic        cmd_wr;
  logic        data_rd;
  logic        data_wr;

  assign cmd_wr  = wr_strobe && addr == `AMCI_OFS_COMMAND && !busy;
  assign data_rd = rd_strobe && addr == `AMCI_OFS_DATA && state == AMCI_SEND;
  assign data_wr = wr_strobe && addr == `AMCI_OFS_DATA && state == AMCI_RECV;

  // Task file writes, locked while busy
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      feature_param          <= 8'h00;
      sector_count           <= 8'h01;
      sector_number_lba_low  <= 8'h01;
      cylinder_low_lba_mid   <= 8'h00;
      cylinder_high_lba_high <= 8'h00;
      drive_head_select      <= 8'hA0;
      command_code           <= 8'h00;
    end else if (wr_strobe && !busy) begin
      case (addr)
        `AMCI_OFS_FEATURE: feature_param          <= wr_data[7:0];
        `AMCI_OFS_SECCNT:  sector_count           <= wr_data[7:0];
        `AMCI_OFS_SECNUM:  sector_number_lba_low  <= wr_data[7:0];
        `AMCI_OFS_CYLLO:   cylinder_low_lba_mid   <= wr_data[7:0];
        `AMCI_OFS_CYLHI:   cylinder_high_lba_high <= wr_data[7:0];
        `AMCI_OFS_DRVHEAD: drive_head_select      <= wr_data[7:0];
        `AMCI_OFS_COMMAND: command_code           <= wr_data[7:0];
        default: ;
      endcase
    end
  end

  // Identify block contents by word index
  function automatic logic [15:0] ident(input logic [7:0] w);
    logic [15:0] v;
    v = 16'h0000;
    case (w)
      8'd0:  v = card.pcmcia_mode ? SIGNATURE : CONFIG_IDE;
      8'd1:  v = def_geom.cyls;
      8'd3:  v = def_geom.heads;
      8'd6:  v = def_geom.spt;
      8'd7:  v = card.capacity[31:16];
      8'd8:  v = card.capacity[15:0];
      8'd22: v = `AMCI_ECC_COUNT;
      8'd47: v = card.max_multiple;
      8'd54: v = cur_geom.cyls;
      8'd55: v = cur_geom.heads;
      8'd56: v = cur_geom.spt;
      8'd57: v = card.capacity[15:0];
      8'd58: v = card.capacity[31:16];
      8'd59: v = {`AMCI_MULT_VALID, card.cur_multiple};
      8'd60: v = card.lba_total[15:0];
      8'd61: v = card.lba_total[31:16];
      8'd63: v = card.pcmcia_mode ? 16'h0000 : card.dma_modes;
      8'd65: v = card.pcmcia_mode ? 16'h0000 : card.dma_min;
      8'd66: v = card.pcmcia_mode ? 16'h0000 : card.dma_rec;
      default: begin
        if (w >= 8'd10 && w <= 8'd19) begin
          v = SERIAL[16*(19-w) +: 16];
        end else if (w >= 8'd23 && w <= 8'd26) begin
          v = FIRMWARE[16*(26-w) +: 16];
        end else if (w >= 8'd27 && w <= 8'd46) begin
          v = MODEL[16*(46-w) +: 16];
        end
      end
    endcase
    return v;
  endfunction

  assign id_word = ident(word_idx[7:0]);

  // Command sequencing
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state     <= AMCI_IDLE;
      word_idx  <= 9'h000;
      fmt_left  <= 9'h000;
      flush_req <= 1'b0;
      erase_req <= 1'b0;
    end else begin
      flush_req <= 1'b0;
      erase_req <= 1'b0;
      case (state)
        AMCI_IDLE: if (cmd_wr) state <= AMCI_EXEC;
        AMCI_EXEC: begin
          word_idx <= 9'h000;
          case (command_code)
            `AMCI_CMD_ERASE: begin
              erase_req <= 1'b1;
              state     <= AMCI_FLUSH;
            end
            `AMCI_CMD_FLUSH: begin
              if (FLUSH_SUPPORTED) begin
                flush_req <= 1'b1;
                state     <= AMCI_FLUSH;
              end else begin
                state <= AMCI_DONE;
              end
            end
            `AMCI_CMD_FORMAT: begin
              if (drive_head_select[`AMCI_LBA_BIT]) begin
                fmt_left <= (sector_count == 8'h00) ? 9'h100 : {1'b0, sector_count};
              end else begin
                fmt_left <= (sector_number_lba_low == 8'h00) ? 9'h100 :
                            {1'b0, sector_number_lba_low};
              end
              state <= AMCI_RECV;
            end
            `AMCI_CMD_IDENTIFY: state <= AMCI_SEND;
            default: state <= AMCI_DONE;
          endcase
        end
        AMCI_FLUSH: if (op_done || flush_done) state <= AMCI_DONE;
        AMCI_SEND: if (data_rd) begin
          word_idx <= word_idx + 9'h001;
          if (word_idx == `AMCI_SECTOR_WORDS - 9'h001) state <= AMCI_DONE;
        end
        AMCI_RECV: if (data_wr) begin
          word_idx <= word_idx + 9'h001;
          if (word_idx == `AMCI_SECTOR_WORDS - 9'h001) begin
            word_idx <= 9'h000;
            state    <= AMCI_FILL;
          end
        end
        AMCI_FILL: begin
          if (word_idx == `AMCI_SECTOR_WORDS - 9'h001) begin
            word_idx <= 9'h000;
            fmt_left <= fmt_left - 9'h001;
            if (fmt_left == 9'h001) state <= AMCI_DONE;
          end else begin
            word_idx <= word_idx + 9'h001;
          end
        end
        AMCI_DONE: state <= AMCI_IDLE;
        default: state <= AMCI_IDLE;
      endcase
    end
  end

  // Format pattern write path
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      media_wr   <= 1'b0;
      media_addr <= 28'h0000000;
      media_data <= 16'h0000;
    end else begin
      media_wr <= state == AMCI_FILL;
      media_data <= `AMCI_FMT_PATTERN;
      if (state == AMCI_EXEC) begin
        media_addr <= {drive_head_select[3:0], cylinder_high_lba_high,
                       cylinder_low_lba_mid, sector_number_lba_low};
      end
    end
  end

  // Status, error and interrupt
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      fault              <= 1'b0;
      err                <= 1'b0;
      error              <= 8'h00;
      seek_complete_flag <= 1'b1;
      host_irq           <= 1'b0;
    end else begin
      if (state == AMCI_EXEC) begin
        fault <= 1'b0;
        err   <= 1'b0;
        error <= 8'h00;
        seek_complete_flag <= 1'b0;
        if (command_code == `AMCI_CMD_FLUSH ? !FLUSH_SUPPORTED :
            !(command_code == `AMCI_CMD_ERASE || command_code == `AMCI_CMD_FORMAT ||
              command_code == `AMCI_CMD_IDENTIFY)) begin
          err   <= 1'b1;
          error <= `AMCI_ERR_ABORT;
        end
      end
      if (state == AMCI_FLUSH && op_fault && command_code == `AMCI_CMD_ERASE) begin
        fault <= 1'b1;
        err   <= 1'b1;
      end
      if (state == AMCI_DONE) seek_complete_flag <= 1'b1;
      if (state == AMCI_DONE || (state == AMCI_SEND && word_idx == 9'h000)) begin
        host_irq <= 1'b1;
      end else if (cmd_wr || (rd_strobe && addr == `AMCI_OFS_COMMAND)) begin
        host_irq <= 1'b0;
      end
    end
  end

  assign busy = state != AMCI_IDLE && state != AMCI_SEND && state != AMCI_RECV;
  assign drq  = state == AMCI_SEND || state == AMCI_RECV;
  assign status = {busy, !busy, fault, seek_complete_flag, drq, 2'b00, err};

  // Read data register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rd_data <= 16'h0000;
    end else if (rd_strobe) begin
      case (addr)
        `AMCI_OFS_DATA:    rd_data <= (state == AMCI_SEND) ? id_word : 16'h0000;
        `AMCI_OFS_FEATURE: rd_data <= {8'h00, error};
        `AMCI_OFS_SECCNT:  rd_data <= {8'h00, sector_count};
        `AMCI_OFS_SECNUM:  rd_data <= {8'h00, sector_number_lba_low};
        `AMCI_OFS_CYLLO:   rd_data <= {8'h00, cylinder_low_lba_mid};
        `AMCI_OFS_CYLHI:   rd_data <= {8'h00, cylinder_high_lba_high};
        `AMCI_OFS_DRVHEAD: rd_data <= {8'h00, drive_head_select};
        `AMCI_OFS_COMMAND: rd_data <= {8'h00, status};
        default: rd_data <= 16'h0000;
      endcase
    end
  end

  chk_flush_ready: assert property (@(posedge clock) disable iff (reset)
    (state == AMCI_DONE && command_code == `AMCI_CMD_FLUSH && FLUSH_SUPPORTED)
    |=> (status[`AMCI_ST_READY] && status[`AMCI_ST_SEEK]))
    else $error("flush done without ready and seek");
  chk_abort_err: assert property (@(posedge clock) disable iff (reset)
    (state == AMCI_EXEC && command_code == `AMCI_CMD_FLUSH && !FLUSH_SUPPORTED)
    |=> ##1 (err && error == `AMCI_ERR_ABORT))
    else $error("unsupported flush not aborted");
  chk_busy_exec: assert property (@(posedge clock) disable iff (reset)
    $rose(cmd_wr) |=> status[`AMCI_ST_BUSY])
    else $error("busy missing after command");
  chk_irq_done: assert property (@(posedge clock) disable iff (reset)
    state == AMCI_DONE |=> host_irq && !busy)
    else $error("no interrupt at completion");
  chk_ecc_word: assert property (@(posedge clock) disable iff (reset)
    (data_rd && word_idx == 9'd22) |=> rd_data == 16'h0004)
    else $error("ecc word wrong");
  chk_mult_valid: assert property (@(posedge clock) disable iff (reset)
    (data_rd && word_idx == 9'd59) |=> rd_data[15:8] == 8'h01)
    else $error("multiple setting not valid");
  chk_pcmcia_dma: assert property (@(posedge clock) disable iff (reset)
    (data_rd && card.pcmcia_mode && word_idx == 9'd63) |=> rd_data == 16'h0000)
    else $error("dma word nonzero in pcmcia mode");
  chk_cap_order: assert property (@(posedge clock) disable iff (reset)
    (data_rd && word_idx == 9'd57) |=> rd_data == $past(card.capacity[15:0]))
    else $error("capacity low half misplaced");
  chk_format_count: assert property (@(posedge clock) disable iff (reset)
    (state == AMCI_EXEC && command_code == `AMCI_CMD_FORMAT &&
     drive_head_select[6] && sector_count == 8'h00) |=> fmt_left == 9'h100)
    else $error("zero count not 256");
  chk_sig_word: assert property (@(posedge clock) disable iff (reset)
    (data_rd && card.pcmcia_mode && word_idx == 9'd0) |=> rd_data == SIGNATURE)
    else $error("signature missing");

  // Command flow and identify content checks
  chk_erase_nodata: assert property (@(posedge clock) disable iff (reset)
    (state == AMCI_EXEC && command_code == `AMCI_CMD_ERASE) |=> (state == AMCI_FLUSH && !drq))
    else $error("pre-erase entered a data phase");
  chk_fault_err: assert property (@(posedge clock) disable iff (reset)
    (state == AMCI_FLUSH && op_fault && command_code == `AMCI_CMD_ERASE)
    |=> (status[`AMCI_ST_FAULT] && status[`AMCI_ST_ERR]))
    else $error("write fault not reported");
  chk_flush_wait: assert property (@(posedge clock) disable iff (reset)
    state == AMCI_FLUSH |-> !seek_complete_flag)
    else $error("seek complete before cache drained");
  chk_fill_pattern: assert property (@(posedge clock) disable iff (reset)
    state == AMCI_FILL |=> (media_wr && media_data == `AMCI_FMT_PATTERN))
    else $error("format pattern not written");
  chk_format_recv: assert property (@(posedge clock) disable iff (reset)
    (state == AMCI_EXEC && command_code == `AMCI_CMD_FORMAT) |=> (state == AMCI_RECV && drq))
    else $error("format did not request a sector");
  chk_recv_count: assert property (@(posedge clock) disable iff (reset)
    (data_wr && word_idx == 9'h0FF) |=> state == AMCI_FILL)
    else $error("format sector not closed after last word");
  chk_format_lba: assert property (@(posedge clock) disable iff (reset)
    (state == AMCI_EXEC && command_code == `AMCI_CMD_FORMAT &&
     drive_head_select[`AMCI_LBA_BIT] && sector_count != 8'h00)
    |=> fmt_left == {1'b0, sector_count})
    else $error("format count not taken from sector count");
  chk_ident_drq: assert property (@(posedge clock) disable iff (reset)
    (state == AMCI_EXEC && command_code == `AMCI_CMD_IDENTIFY)
    |=> (state == AMCI_SEND && drq && !busy))
    else $error("identify data not offered");
  chk_send_count: assert property (@(posedge clock) disable iff (reset)
    (data_rd && word_idx == 9'h0FF) |=> state == AMCI_DONE)
    else $error("identify not closed after last word");
  chk_word0_ide: assert property (@(posedge clock) disable iff (reset)
    (data_rd && !card.pcmcia_mode && word_idx == 9'd0) |=> rd_data == CONFIG_IDE)
    else $error("configuration word wrong");
  chk_card_order: assert property (@(posedge clock) disable iff (reset)
    (data_rd && word_idx == 9'd7) |=> rd_data == $past(card.capacity[31:16]))
    else $error("sectors per card high half misplaced");
  chk_pcmcia_rec: assert property (@(posedge clock) disable iff (reset)
    (data_rd && card.pcmcia_mode && word_idx == 9'd66) |=> rd_data == 16'h0000)
    else $error("dma cycle word nonzero in pcmcia mode");
  chk_reserved_zero: assert property (@(posedge clock) disable iff (reset)
    (data_rd && word_idx >= 9'd69) |=> rd_data == 16'h0000)
    else $error("reserved identify word nonzero");
  chk_irq_clear: assert property (@(posedge clock) disable iff (reset)
    (state == AMCI_IDLE && rd_strobe && addr == `AMCI_OFS_COMMAND) |=> !host_irq)
    else $error("status read did not clear interrupt");
endmodule // amci_cmd
`default_nettype wire

// file: amci_cmd_tb.sv
// Self-checking bench for the media command and identify block
`timescale 1ns/1ps
`default_nettype none
module amci_cmd_tb;
  import amci_pkg::*;
  localparam logic [15:0] SIG = 16'h5A5A;  // Arbitrary value
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        wr_strobe = 1'b0;
  logic        rd_strobe = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [15:0] wr_data = 16'h0000;
  logic        fault_en = 1'b0;
  logic [15:0] rd_data, media_data;
  logic [7:0]  status, error, status_nf, error_nf;
  logic        host_irq, flush_req, flush_done, media_wr;
  logic        erase_req, op_done, op_fault;
  logic [27:0] media_addr;
  amci_geom_t  def_geom = '{16'h03C4, 16'h0010, 16'h003F};
  amci_geom_t  cur_geom = '{16'h01E2, 16'h0008, 16'h0020};
  amci_card_t  card = '{32'h0001_2345, 32'h0001_2345, 16'h8010, 8'h08,
                        16'h0407, 16'h0078, 16'h0096, 1'b0};
  logic [15:0] words [256];
  int          errors = 0;
  int          cmp_count = 0;
  int          k;
  int          bad;
  logic [15:0] rv;
  // Identify word index beside expected word
  logic [23:0] rows [30] = '{
    24'h000040, 24'h0103C4, 24'h030010, 24'h06003F, 24'h070001, 24'h082345,
    24'h0A2020, 24'h12534E, 24'h133031, 24'h160004, 24'h174142, 24'h1A4748,
    24'h1B4D4F, 24'h1D4C20, 24'h2E2020, 24'h2F8010, 24'h3601E2, 24'h370008,
    24'h380020, 24'h392345, 24'h3A0001, 24'h3B0108, 24'h3F0407, 24'h410078,
    24'h420096, 24'h3C2345, 24'h3D0001, 24'h020000, 24'h640000, 24'hC80000};
  // Format sector count beside media writes expected
  logic [24:0] fmt [2] = '{{8'h02, 17'd512}, {8'h00, 17'd65536}};

  always #5 clock = ~clock;

  amci_cmd #(.SIGNATURE(SIG), .SERIAL({{16{8'h20}}, "SN01"}),
    .FIRMWARE("ABCDEFGH"), .MODEL({"MODEL", {35{8'h20}}})) dut (
    .clock, .reset, .wr_strobe, .rd_strobe, .addr, .wr_data, .rd_data,
    .status, .error, .host_irq, .def_geom, .cur_geom, .card, .flush_req,
    .flush_done, .media_wr, .media_addr, .media_data, .erase_req, .op_done,
    .op_fault);
  amci_cmd #(.SIGNATURE(SIG), .FLUSH_SUPPORTED(1'b0)) dut_nf (
    .clock, .reset, .wr_strobe, .rd_strobe, .addr, .wr_data, .rd_data(),
    .status(status_nf), .error(error_nf), .host_irq(), .def_geom, .cur_geom,
    .card, .flush_req(), .flush_done, .media_wr(), .media_addr(),
    .media_data(), .erase_req(), .op_done, .op_fault);
  amci_media_model #(.DELAY(6)) partner (
    .clock, .reset, .flush_req, .erase_req, .fault_en, .flush_done, .op_done,
    .op_fault);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [2:0] a, input logic [15:0] d);
    @(negedge clock);
    wr_strobe = 1'b1;
    addr = a;
    wr_data = d;
    @(negedge clock);
    wr_strobe = 1'b0;
  endtask

  task automatic bus_rd(input logic [2:0] a, output logic [15:0] v);
    @(negedge clock);
    rd_strobe = 1'b1;
    addr = a;
    @(negedge clock);
    rd_strobe = 1'b0;
    v = rd_data;
  endtask

  // Wait for a status bit, bounded; returns cycles spent
  task automatic wait_bit(input int b, input logic v, output int n);
    n = 0;
    while (status[b] !== v && n < 2000) begin
      @(negedge clock);
      n++;
    end
    check(status[b], v);
  endtask

  task automatic identify();
    bus_wr(3'h7, 16'h00EC);
    wait_bit(3, 1'b1, k);
    for (int i = 0; i < 256; i++) bus_rd(3'h0, words[i]);
    wait_bit(7, 1'b0, k);
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #900_000;
    errors++;
    complete_run();
  end

  initial begin
    repeat (12) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    check(status, 8'h50);
    check(host_irq, 1'b0);
    identify();
    foreach (rows[r]) check(words[rows[r][23:16]], rows[r][15:0]);
    check(host_irq, 1'b1);
    card.pcmcia_mode = 1'b1;
    identify();
    check(words[0], SIG);
    check(words[63] | words[65] | words[66], 16'h0000);
    card.pcmcia_mode = 1'b0;
    bus_wr(3'h7, 16'h00E7);
    check(status[7], 1'b1);
    wait_bit(7, 1'b0, k);
    check(k >= 6, 1'b1);
    check({status[6], status[4], status[0]}, 3'b110);
    check(host_irq, 1'b1);
    check({status_nf[0], error_nf}, 9'h104);
    bus_rd(3'h7, rv);
    check(rv, 16'h0050);
    check(host_irq, 1'b0);
    fault_en = 1'b1;
    bus_wr(3'h6, 16'h00E3);
    bus_wr(3'h5, 16'h0012);
    bus_wr(3'h4, 16'h0034);
    bus_wr(3'h3, 16'h0056);
    bus_wr(3'h2, 16'h0001);
    bus_wr(3'h7, 16'h00C0);
    wait_bit(7, 1'b0, k);
    check({status[5], status[3], status[0]}, 3'b101);
    check(media_addr, 28'h3123456);
    bus_rd(3'h3, rv);
    check(rv, 16'h0056);
    fault_en = 1'b0;
    foreach (fmt[i]) begin
      bus_wr(3'h6, 16'h00E3);
      bus_wr(3'h2, {8'h00, fmt[i][24:17]});
      bus_wr(3'h7, 16'h0050);
      wait_bit(3, 1'b1, k);
      for (int j = 0; j < 256; j++) bus_wr(3'h0, 16'hA5C3);
      k = 0;
      bad = 0;
      for (int g = 0; g < 70000 && !(k > 0 && status[7] === 1'b0); g++) begin
        @(negedge clock);
        if (media_wr === 1'b1) begin
          k++;
          if (media_data !== 16'hFFFF) bad++;
        end
      end
      check(k, {15'h0, fmt[i][16:0]});
      check(bad, 0);
      check(status[3], 1'b0);
    end
    bus_wr(3'h7, 16'h0000);
    wait_bit(7, 1'b0, k);
    check({status[0], error}, 9'h104);
    bus_wr(3'h7, 16'h00EC);
    wait_bit(3, 1'b1, k);
    @(negedge clock);
    reset = 1'b1;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    check(status, 8'h50);
    check({host_irq, rd_data}, 17'h00000);
    complete_run();
  end
endmodule  // amci_cmd_tb
`default_nettype wire

// file: amci_defs.svh
// Constants for the media command and identify block
`ifndef AMCI_DEFS_SVH
`define AMCI_DEFS_SVH
`define AMCI_OFS_FEATURE   3'h1
`define AMCI_OFS_SECCNT    3'h2
`define AMCI_OFS_SECNUM    3'h3
`define AMCI_OFS_CYLLO     3'h4
`define AMCI_OFS_CYLHI     3'h5
`define AMCI_OFS_DRVHEAD   3'h6
`define AMCI_OFS_COMMAND   3'h7
`define AMCI_OFS_DATA      3'h0
`define AMCI_CMD_ERASE     8'hC0
`define AMCI_CMD_FLUSH     8'hE7
`define AMCI_CMD_FORMAT    8'h50
`define AMCI_CMD_IDENTIFY  8'hEC
`define AMCI_LBA_BIT       6
`define AMCI_ST_BUSY       7
`define AMCI_ST_READY      6
`define AMCI_ST_FAULT      5
`define AMCI_ST_SEEK       4
`define AMCI_ST_DRQ        3
`define AMCI_ST_ERR        0
`define AMCI_ERR_ABORT     8'h04
`define AMCI_ECC_COUNT     16'h0004
`define AMCI_MULT_VALID    8'h01
`define AMCI_FMT_PATTERN   16'hFFFF
`define AMCI_SECTOR_WORDS  9'h100
`endif

// file: amci_media_model.sv
// Media back end model answering flush and erase requests
`timescale 1ns/1ps
`default_nettype none
module amci_media_model #(
  parameter int DELAY = 6
) (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic flush_req,
  input  wire logic erase_req,
  input  wire logic fault_en,
  output logic      flush_done,
  output logic      op_done,
  output logic      op_fault
);
  int   cnt;
  logic kind;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt <= 0;
      kind <= 1'b0;
      flush_done <= 1'b0;
      op_done <= 1'b0;
      op_fault <= 1'b0;
    end else begin
      flush_done <= 1'b0;
      op_done <= 1'b0;
      op_fault <= 1'b0;
      if (flush_req || erase_req) begin
        cnt <= DELAY;
        kind <= erase_req;
      end else if (cnt == 1) begin
        // Cache drained only after the full delay
        flush_done <= !kind;
        op_done <= kind;
        op_fault <= kind && fault_en;
        cnt <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule  // amci_media_model
`default_nettype wire

// file: amci_pkg.sv
// Types for the media command and identify block
package amci_pkg;
  typedef enum logic [2:0] {
    AMCI_IDLE, AMCI_EXEC, AMCI_FLUSH, AMCI_SEND, AMCI_RECV, AMCI_FILL, AMCI_DONE
  } amci_state_t;
  typedef struct packed {
    logic [15:0] cyls;
    logic [15:0] heads;
    logic [15:0] spt;
  } amci_geom_t;
  typedef struct packed {
    logic [31:0] capacity;
    logic [31:0] lba_total;
    logic [15:0] max_multiple;
    logic [7:0]  cur_multiple;
    logic [15:0] dma_modes;
    logic [15:0] dma_min;
    logic [15:0] dma_rec;
    logic        pcmcia_mode;
  } amci_card_t;
endpackage
